// ### core/dsp_dp_pkg.sv
`default_nettype none
package dsp_dp_pkg;
  localparam int DATA_W   = 16;
  localparam int ACC_W    = 40;
  localparam int TOP_W    = 8;
  localparam int PROD_W   = 32;
  localparam int DIV_STEPS_UNSIGNED = 16;
  localparam int DIV_STEPS_SIGNED_Q = 15;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [39:0] ACC_RESET  = 40'h00_0000_0000;
  // status word bit positions
  localparam int ST_ZERO  = 0;
  localparam int ST_NEG   = 1;
  localparam int ST_AVF   = 2;
  localparam int ST_CARRY = 3;
  localparam int ST_XSIGN = 4;
  localparam int ST_QUOT  = 5;
  localparam int ST_MOVF  = 6;
  localparam int ST_W     = 7;
  localparam logic [6:0] STATUS_RESET = 7'h00;

  typedef enum logic [2:0] {
    ALU_NOP    = 3'b000,
    ALU_ADD    = 3'b001,
    ALU_SUB    = 3'b010,
    ALU_MAG    = 3'b011,
    ALU_DSIGN  = 3'b100,
    ALU_DQUOT  = 3'b101
  } alu_op_t;

  typedef enum logic [2:0] {
    MAC_NOP = 3'b000,
    MAC_MUL = 3'b001,
    MAC_ADD = 3'b010,
    MAC_SUB = 3'b011,
    MAC_CLR = 3'b100
  } mac_op_t;

  // register selectors for bus reads/writes
  typedef enum logic [3:0] {
    SEL_NONE = 4'h0,
    SEL_MX0  = 4'h1,
    SEL_MX1  = 4'h2,
    SEL_MY0  = 4'h3,
    SEL_MY1  = 4'h4,
    SEL_ACC0 = 4'h5,
    SEL_ACC1 = 4'h6,
    SEL_ACC2 = 4'h7,
    SEL_MF   = 4'h8,
    SEL_AF   = 4'h9,
    SEL_YLO  = 4'ha,
    SEL_STAT = 4'hb
  } reg_sel_t;

  typedef struct packed {
    alu_op_t          op;
    logic [15:0]      x;
    logic [15:0]      y;
    logic             y_from_fb;
  } alu_cmd_t;

  typedef struct packed {
    mac_op_t     op;
    logic        x_from_rbus;
    logic        x_idx;
    logic        y_from_fb;
    logic        y_idx;
    logic        x_signed;
    logic        y_signed;
    logic        to_fb;
  } mac_cmd_t;
endpackage : dsp_dp_pkg
`default_nettype wire

// ### core/dsp_bank_regs.sv
`default_nettype none
// two-bank file of small operand registers, dual read, registered bus read
module dsp_bank_regs
  import dsp_dp_pkg::*;
#(
  parameter int W = 16,
  parameter int N = 2
)(
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  input  wire logic                 bank,
  input  wire logic                 wr_en,
  input  wire logic [$clog2(N)-1:0] wr_idx,
  input  wire logic [W-1:0]         wr_data,
  input  wire logic [$clog2(N)-1:0] op_idx,
  output logic      [W-1:0]         op_data,
  input  wire logic [$clog2(N)-1:0] rd_idx,
  output logic      [W-1:0]         rd_data_q
);
  logic [W-1:0] mem_q [2][N];

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      for (int b = 0; b < 2; b++)
        for (int i = 0; i < N; i++)
          mem_q[b][i] <= '0;
    end
    else if (wr_en)
      mem_q[bank][wr_idx] <= wr_data;
  end

  // operand port reads old value: write lands at cycle end
  assign op_data = mem_q[bank][op_idx];

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      rd_data_q <= '0;
    else
      rd_data_q <= mem_q[bank][rd_idx];
  end
endmodule : dsp_bank_regs
`default_nettype wire

// ### core/dsp_datapath.sv
`default_nettype none
module dsp_datapath
  import dsp_dp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        bank_sel,
  input  wire alu_cmd_t    alu_cmd,
  input  wire mac_cmd_t    mac_cmd,
  input  wire logic [15:0] rbus_in,
  input  wire reg_sel_t    dm_wr_sel,
  input  wire logic [15:0] dm_wr_data,
  input  wire logic        pm_wr_en,
  input  wire logic        pm_wr_idx,
  input  wire logic [15:0] pm_wr_data,
  input  wire reg_sel_t    dm_rd_sel,
  input  wire reg_sel_t    rb_rd_sel,
  output logic      [15:0] data_side_bus_q,
  output logic      [15:0] result_bus_q,
  output logic      [6:0]  arith_status_word_q,
  output logic      [15:0] y_low_operand_q,
  output logic      [15:0] alu_feedback_q
);
  ////////////////////////////////////////////////////////////////////////////
  // banked mac state and the unbanked status word
  logic [15:0] acc_lo_q [2];
  logic [15:0] acc_mid_q [2];
  logic [7:0]  acc_top_q [2];
  logic [15:0] mf_q [2];
  logic [6:0]  stat_q;
  logic        b;
  assign b = bank_sel;

  ////////////////////////////////////////////////////////////////////////////
  // operand files
  logic [15:0] mx_op;
  logic [15:0] my_op;
  logic [15:0] mx_rd;
  logic [15:0] my_rd;
  logic        mx_we;
  logic        my_we;
  logic        mx_wi;
  logic        my_wi;
  logic [15:0] my_wd;
  logic        mx_ri;
  logic        my_ri;

  assign mx_we = (dm_wr_sel == SEL_MX0) || (dm_wr_sel == SEL_MX1);
  assign mx_wi = (dm_wr_sel == SEL_MX1);
  // program bus write wins over data bus write to the y file
  assign my_we = pm_wr_en || (dm_wr_sel == SEL_MY0) || (dm_wr_sel == SEL_MY1);
  assign my_wi = pm_wr_en ? pm_wr_idx : (dm_wr_sel == SEL_MY1);
  assign my_wd = pm_wr_en ? pm_wr_data : dm_wr_data;
  assign mx_ri = (dm_rd_sel == SEL_MX1);
  assign my_ri = (dm_rd_sel == SEL_MY1);

  dsp_bank_regs #(.W(16), .N(2)) u_mx (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .bank      (b),
    .wr_en     (mx_we),
    .wr_idx    (mx_wi),
    .wr_data   (dm_wr_data),
    .op_idx    (mac_cmd.x_idx),
    .op_data   (mx_op),
    .rd_idx    (mx_ri),
    .rd_data_q (mx_rd)
  );

  dsp_bank_regs #(.W(16), .N(2)) u_my (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .bank      (b),
    .wr_en     (my_we),
    .wr_idx    (my_wi),
    .wr_data   (my_wd),
    .op_idx    (mac_cmd.y_idx),
    .op_data   (my_op),
    .rd_idx    (my_ri),
    .rd_data_q (my_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // multiplier and accumulate
  logic [15:0] mul_x;
  logic [15:0] mul_y;
  logic [16:0] sx;
  logic [16:0] sy;
  logic [33:0] prod_full;
  logic [31:0] prod;
  logic [39:0] prod_al;
  logic [39:0] acc_cur;
  logic [39:0] acc_res;
  logic        acc_ovf;

  assign mul_x = mac_cmd.x_from_rbus ? rbus_in : mx_op;
  assign mul_y = mac_cmd.y_from_fb ? mf_q[b] : my_op;
  assign sx = {mac_cmd.x_signed & mul_x[15], mul_x};
  assign sy = {mac_cmd.y_signed & mul_y[15], mul_y};
  // operands widen to 17 bits before the multiply; prod keeps only the low 32 of the 34 product bits
  assign prod_full = $signed(sx) * $signed(sy);
  assign prod = prod_full[31:0];
  // top byte gets sign of the product, lsb zero filled
  assign prod_al = {{7{prod[31]}}, prod, 1'b0};
  assign acc_cur = {acc_top_q[b], acc_mid_q[b], acc_lo_q[b]};

  always_comb
  begin
    case (mac_cmd.op)
      MAC_MUL: acc_res = prod_al;
      MAC_ADD: acc_res = acc_cur + prod_al;
      MAC_SUB: acc_res = acc_cur - prod_al;
      MAC_CLR: acc_res = ACC_RESET;
      default: acc_res = acc_cur;
    endcase
  end

  // top nine bits not all equal
  assign acc_ovf = !((&acc_res[39:31]) || !(|acc_res[39:31]));

  logic mac_act;
  assign mac_act = (mac_cmd.op != MAC_NOP);

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < 2; i++)
      begin
        acc_lo_q[i]  <= WORD_RESET;
        acc_mid_q[i] <= WORD_RESET;
        acc_top_q[i] <= 8'h00;
      end
    end
    else
    begin
      if (mac_act && !mac_cmd.to_fb)
      begin
        {acc_top_q[b], acc_mid_q[b], acc_lo_q[b]} <= acc_res;
      end
      // a bus load in the same cycle lands after the mac result
      if (dm_wr_sel == SEL_ACC0)
        acc_lo_q[b] <= dm_wr_data;
      if (dm_wr_sel == SEL_ACC1)
      begin
        acc_mid_q[b] <= dm_wr_data;
        acc_top_q[b] <= {8{dm_wr_data[15]}};
      end
      if (dm_wr_sel == SEL_ACC2)
        acc_top_q[b] <= dm_wr_data[7:0];
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      mf_q[0] <= WORD_RESET;
      mf_q[1] <= WORD_RESET;
    end
    else if (mac_act && mac_cmd.to_fb)
      mf_q[b] <= acc_res[31:16];
    else if (dm_wr_sel == SEL_MF)
      mf_q[b] <= dm_wr_data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // alu with divide primitives
  logic [15:0] ylo_q;
  logic [15:0] af_q;
  logic [15:0] a_y;
  logic [16:0] a_sum;
  logic [15:0] a_res;
  logic        c14;
  logic        c15;
  logic        a_sub;
  logic [15:0] a_b;
  logic        quo;
  logic        div_op;

  assign a_y = alu_cmd.y_from_fb ? af_q : alu_cmd.y;
  assign div_op = (alu_cmd.op == ALU_DSIGN) || (alu_cmd.op == ALU_DQUOT);

  always_comb
  begin
    a_sub = 1'b0;
    a_b   = 16'h0000;
    case (alu_cmd.op)
      ALU_ADD:   a_b = a_y;
      ALU_SUB:
      begin
        a_sub = 1'b1;
        a_b   = a_y;
      end
      ALU_MAG:   a_sub = alu_cmd.x[15];
      ALU_DQUOT: a_sub = !stat_q[ST_QUOT];
      default:   a_sub = 1'b0;
    endcase
  end

  logic [15:0] a_l;
  logic [15:0] a_r;
  always_comb
  begin
    case (alu_cmd.op)
      ALU_MAG:
      begin
        a_l = a_sub ? 16'h0000 : alu_cmd.x;
        a_r = alu_cmd.x;
      end
      ALU_DSIGN:
      begin
        a_l = a_y;
        a_r = 16'h0000;
      end
      ALU_DQUOT:
      begin
        a_l = a_y;                         // remainder
        a_r = alu_cmd.x;                   // divisor
      end
      default:
      begin
        a_l = alu_cmd.x;
        a_r = a_b;
      end
    endcase
  end

  logic [15:0] a_rr;
  logic [15:0] lowsum;
  logic        lowc;
  assign a_rr = (alu_cmd.op == ALU_MAG && !a_sub) ? 16'h0000 : (a_sub ? ~a_r : a_r);
  assign {lowc, lowsum[14:0]} = {1'b0, a_l[14:0]} + {1'b0, a_rr[14:0]} + 16'(a_sub);
  assign c14 = lowc;
  assign a_sum = {1'b0, a_l} + {1'b0, a_rr} + 17'(a_sub);
  assign c15 = a_sum[16];
  assign lowsum[15] = a_sum[15];
  assign a_res = a_sum[15:0];

  // sign step: divisor sign xor dividend sign
  assign quo = (alu_cmd.op == ALU_DSIGN) ? (alu_cmd.x[15] ^ a_y[15])
             : (alu_cmd.x[15] ^ a_res[15]);

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      ylo_q <= WORD_RESET;
      af_q  <= WORD_RESET;
    end
    else if (div_op)
    begin
      af_q  <= {a_res[14:0], ylo_q[15]};
      ylo_q <= (alu_cmd.op == ALU_DQUOT) ? {ylo_q[14:0], !quo}
                                         : {ylo_q[14:0], quo};
    end
    else
    begin
      if (alu_cmd.op != ALU_NOP)
        af_q <= a_res;
      else if (dm_wr_sel == SEL_AF)
        af_q <= dm_wr_data;
      if (dm_wr_sel == SEL_YLO)
        ylo_q <= dm_wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status word
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      stat_q <= STATUS_RESET;
    else
    begin
      if (dm_wr_sel == SEL_STAT)
        stat_q <= dm_wr_data[ST_W-1:0];
      if (alu_cmd.op != ALU_NOP)
      begin
        stat_q[ST_ZERO]  <= ~|a_res;
        stat_q[ST_NEG]   <= a_res[15];
        stat_q[ST_AVF]   <= c14 ^ c15;
        stat_q[ST_CARRY] <= c15;
      end
      if (alu_cmd.op == ALU_MAG)
        stat_q[ST_XSIGN] <= alu_cmd.x[15];
      if (div_op)
        stat_q[ST_QUOT] <= quo;
      if (mac_act)
        stat_q[ST_MOVF] <= acc_ovf;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus read mux, registered: shows start-of-cycle values
  function automatic logic [15:0] pick(input reg_sel_t s, input logic [15:0] mxv,
                                       input logic [15:0] myv);
    case (s)
      SEL_MX0, SEL_MX1: pick = mxv;
      SEL_MY0, SEL_MY1: pick = myv;
      SEL_ACC0: pick = acc_lo_q[b];
      SEL_ACC1: pick = acc_mid_q[b];
      SEL_ACC2: pick = {{8{acc_top_q[b][7]}}, acc_top_q[b]};
      SEL_MF:   pick = mf_q[b];
      SEL_AF:   pick = af_q;
      SEL_YLO:  pick = ylo_q;
      SEL_STAT: pick = {9'h000, stat_q};
      default:  pick = 16'h0000;
    endcase
  endfunction : pick

  // operand file read data is already a cycle late; its registered value passes through the bus register too
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      data_side_bus_q <= WORD_RESET;
      result_bus_q    <= WORD_RESET;
    end
    else
    begin
      data_side_bus_q <= pick(dm_rd_sel, mx_rd, my_rd);
      result_bus_q    <= pick(rb_rd_sel, mx_rd, my_rd);
    end
  end

  assign arith_status_word_q = stat_q;
  assign y_low_operand_q     = ylo_q;
  assign alu_feedback_q      = af_q;

  ////////////////////////////////////////////////////////////////////////////
  a_zero_flag: assert property (@(posedge sys_clk) disable iff (reset)
    (alu_cmd.op == ALU_ADD) |=> (stat_q[ST_ZERO] == (af_q == 16'h0000)))
    else $error("zero flag mismatch");
  a_quot_hold: assert property (@(posedge sys_clk) disable iff (reset)
    (!div_op && dm_wr_sel != SEL_STAT) |=> $stable(stat_q[ST_QUOT]))
    else $error("quotient flag changed");
  a_quot_bit: assert property (@(posedge sys_clk) disable iff (reset)
    (alu_cmd.op == ALU_DQUOT) |=> (ylo_q[0] == !stat_q[ST_QUOT]))
    else $error("quotient bit not inverse");
  a_fb_offset: assert property (@(posedge sys_clk) disable iff (reset)
    div_op |=> (af_q[0] == $past(ylo_q[15])))
    else $error("feedback lsb wrong");
  a_mac_clear: assert property (@(posedge sys_clk) disable iff (reset)
    (mac_cmd.op == MAC_CLR && !mac_cmd.to_fb && dm_wr_sel == SEL_NONE)
    |=> ({acc_top_q[b], acc_mid_q[b], acc_lo_q[b]} == 40'h00_0000_0000))
    else $error("accumulator not cleared");
  a_mid_ext: assert property (@(posedge sys_clk) disable iff (reset)
    (dm_wr_sel == SEL_ACC1) |=> (acc_top_q[b] == {8{acc_mid_q[b][15]}}))
    else $error("top byte not extended");
  a_acc_lsb: assert property (@(posedge sys_clk) disable iff (reset)
    (mac_cmd.op == MAC_MUL && !mac_cmd.to_fb && dm_wr_sel == SEL_NONE)
    |=> (acc_lo_q[b][0] == 1'b0))
    else $error("product lsb not zero");
  a_mac_ovf: assert property (@(posedge sys_clk) disable iff (reset)
    (mac_act && dm_wr_sel != SEL_STAT) |=> (stat_q[ST_MOVF] == $past(acc_ovf)))
    else $error("accumulator overflow flag wrong");
endmodule : dsp_datapath
`default_nettype wire

// ### bench/issue_unit.sv
`default_nettype none
// issuer model: owns alu commands and data-bus writes
module issue_unit
  import dsp_dp_pkg::*;
(
  input  wire logic        sys_clk,
  output var  alu_cmd_t    alu_cmd,
  output var  reg_sel_t    dm_wr_sel,
  output logic      [15:0] dm_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    alu_cmd    = '{ALU_NOP, 16'h0000, 16'h0000, 1'b0};
    dm_wr_sel  = SEL_NONE;
    dm_wr_data = 16'h0000;
  end
  task automatic wr(input reg_sel_t sel, input logic [15:0] d);
    @(negedge sys_clk);
    dm_wr_sel  = sel;
    dm_wr_data = d;
    @(negedge sys_clk);
    dm_wr_sel  = SEL_NONE;
    // idle bus must not keep showing the old word
    dm_wr_data = ~d;
  endtask : wr
  task automatic alu(input alu_op_t op, input logic [15:0] x, input logic [15:0] y,
                     input logic fb);
    @(negedge sys_clk);
    alu_cmd = '{op, x, y, fb};
    @(negedge sys_clk);
    alu_cmd = '{ALU_NOP, ~x, ~y, 1'b0};
  endtask : alu
  task automatic divide(input logic [31:0] dvd, input logic [15:0] dvs, input logic sgn);
    wr(SEL_AF, dvd[31:16]);
    wr(SEL_YLO, dvd[15:0]);
    if (sgn)
      alu(ALU_DSIGN, dvs, 16'h0000, 1'b1);
    else
      wr(SEL_STAT, 16'h0000);
    repeat (sgn ? 15 : 16) alu(ALU_DQUOT, dvs, 16'h0000, 1'b1);
  endtask : divide
endmodule : issue_unit
`default_nettype wire

// ### bench/alu_divide_and_mac_datapath_bench.sv
`default_nettype none
module alu_divide_and_mac_datapath_bench
  import dsp_dp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk;
  logic        reset;
  logic        bank_sel;
  logic        pm_wr_en;
  logic        pm_wr_idx;
  logic [15:0] pm_wr_data;
  logic [15:0] rbus_in;
  alu_cmd_t    alu_cmd;
  mac_cmd_t    mac_cmd;
  reg_sel_t    dm_wr_sel;
  reg_sel_t    dm_rd_sel;
  reg_sel_t    rb_rd_sel;
  logic [15:0] dm_wr_data;
  logic [15:0] data_side_bus_q;
  logic [15:0] result_bus_q;
  logic [15:0] y_low_operand_q;
  logic [15:0] alu_feedback_q;
  logic [6:0]  arith_status_word_q;
  logic [6:0]  st_m;
  logic [39:0] acc_m [2];
  logic [15:0] mf_m [2];
  int          fail_count;
  int          samples_checked;

  dsp_datapath dut (.sys_clk(sys_clk), .reset(reset), .bank_sel(bank_sel),
    .alu_cmd(alu_cmd), .mac_cmd(mac_cmd), .rbus_in(rbus_in), .dm_wr_sel(dm_wr_sel),
    .dm_wr_data(dm_wr_data), .pm_wr_en(pm_wr_en), .pm_wr_idx(pm_wr_idx),
    .pm_wr_data(pm_wr_data), .dm_rd_sel(dm_rd_sel), .rb_rd_sel(rb_rd_sel),
    .data_side_bus_q(data_side_bus_q), .result_bus_q(result_bus_q),
    .arith_status_word_q(arith_status_word_q), .y_low_operand_q(y_low_operand_q),
    .alu_feedback_q(alu_feedback_q));
  issue_unit u_iss (.sys_clk(sys_clk), .alu_cmd(alu_cmd), .dm_wr_sel(dm_wr_sel),
    .dm_wr_data(dm_wr_data));

  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;
  //////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  // both buses are read together so either path can show a slip
  task automatic rd(input reg_sel_t sel, input logic [15:0] exp);
    @(negedge sys_clk);
    dm_rd_sel = sel;
    rb_rd_sel = sel;
    @(negedge sys_clk);
    chk(sel.name(), 40'(data_side_bus_q), 40'(exp));
    chk("result bus", 40'(result_bus_q), 40'(exp));
    dm_rd_sel = SEL_NONE;
    rb_rd_sel = SEL_NONE;
  endtask : rd
  task automatic rd_acc();
    logic [39:0] a;
    a = acc_m[bank_sel];
    rd(SEL_ACC0, a[15:0]);
    rd(SEL_ACC1, a[31:16]);
    rd(SEL_ACC2, {{8{a[39]}}, a[39:32]});
    chk("status", 40'(arith_status_word_q), 40'(st_m));
  endtask : rd_acc
  task automatic mac(input mac_op_t op, input logic [15:0] x, input logic [15:0] y,
                     input logic fb, input logic xr, input logic yf);
    logic [31:0] p;
    logic [39:0] e;
    logic [39:0] r;
    logic [15:0] yv;
    yv = yf ? mf_m[bank_sel] : y;
    if (!xr)
      u_iss.wr(SEL_MX0, x);
    @(negedge sys_clk);
    pm_wr_en   = 1'b1;
    pm_wr_data = y;
    @(negedge sys_clk);
    // overwrite in the operand cycle: old value must be used
    pm_wr_data = ~y;
    rbus_in    = xr ? x : ~x;
    mac_cmd    = '{op, xr, 1'b0, yf, 1'b0, 1'b1, 1'b1, fb};
    @(negedge sys_clk);
    pm_wr_en   = 1'b0;
    rbus_in    = ~x;
    mac_cmd.op = MAC_NOP;
    p = $signed({{16{x[15]}}, x}) * $signed({{16{yv[15]}}, yv});
    e = {{7{p[31]}}, p, 1'b0};
    case (op)
      MAC_ADD: r = acc_m[bank_sel] + e;
      MAC_SUB: r = acc_m[bank_sel] - e;
      MAC_CLR: r = 40'h00_0000_0000;
      default: r = e;
    endcase
    if (fb)
      mf_m[bank_sel] = r[31:16];
    else
      acc_m[bank_sel] = r;
    st_m[ST_MOVF] = !((&r[39:31]) || !(|r[39:31]));
  endtask : mac
  //////////////////////////////////////////////////
  task automatic div_chk(input logic [31:0] dvd, input logic [15:0] dvs, input logic sgn);
    logic [15:0] af;
    logic [15:0] yl;
    logic [15:0] r;
    logic        q;
    u_iss.divide(dvd, dvs, sgn);
    af = dvd[31:16];
    yl = dvd[15:0];
    q  = 1'b0;
    if (!sgn)
      st_m = 7'h00;
    if (sgn)
    begin
      q  = dvs[15] ^ af[15];
      af = {af[14:0], yl[15]};
      yl = {yl[14:0], q};
    end
    repeat (sgn ? 15 : 16)
    begin
      r  = q ? af + dvs : af - dvs;
      q  = dvs[15] ^ r[15];
      af = {r[14:0], yl[15]};
      yl = {yl[14:0], ~q};
    end
    st_m[ST_QUOT] = q;
    chk("quotient", 40'(y_low_operand_q), 40'(yl));
    chk("remainder", 40'(alu_feedback_q), 40'(af));
    chk("quot flag", 40'(arith_status_word_q[ST_QUOT]), 40'(q));
  endtask : div_chk
  task automatic add_chk(input logic [15:0] x, input logic [15:0] y);
    logic [16:0] s;
    u_iss.alu(ALU_ADD, x, y, 1'b0);
    s = {1'b0, x} + {1'b0, y};
    st_m[ST_ZERO]  = ~|s[15:0];
    st_m[ST_NEG]   = s[15];
    st_m[ST_CARRY] = s[16];
    st_m[ST_AVF]   = s[16] ^ (x[15] ^ y[15] ^ s[15]);
    chk("status", 40'(arith_status_word_q), 40'(st_m));
  endtask : add_chk
  task automatic mag_chk(input logic [15:0] x);
    u_iss.alu(ALU_MAG, x, 16'h0000, 1'b0);
    st_m[ST_XSIGN] = x[15];
    chk("sign flags", 40'(arith_status_word_q[5:4]), 40'(st_m[5:4]));
  endtask : mag_chk
  //////////////////////////////////////////////////
  initial
  begin
    #100000;
    fail_count++;
    close_out();
  end
  initial
  begin
    void'($urandom(75395));
    reset = 1'b1;
    bank_sel = 1'b0;
    pm_wr_en = 1'b0;
    pm_wr_idx = 1'b0;
    pm_wr_data = 16'h0000;
    rbus_in = 16'h0000;
    mac_cmd = '{MAC_NOP, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    dm_rd_sel = SEL_NONE;
    rb_rd_sel = SEL_NONE;
    fail_count = 0;
    samples_checked = 0;
    st_m = 7'h00;
    acc_m = '{default: 40'h00_0000_0000};
    mf_m = '{default: 16'h0000};
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    chk("reset status", 40'(arith_status_word_q), 40'(STATUS_RESET));
    for (int i = 0; i < 6; i++)
      div_chk($urandom(), 16'($urandom()) | 16'h0001, i[0]);
    add_chk(16'h7fff, 16'h0001);
    add_chk(16'h8000, 16'h8000);
    add_chk(16'hffff, 16'h0001);
    add_chk(16'h0000, 16'h0000);
    repeat (8) add_chk(16'($urandom()), 16'($urandom()));
    mag_chk(16'h8000);
    add_chk(16'h0001, 16'h0001);
    mag_chk(16'h0001);
    add_chk(16'h4000, 16'h4000);
    mac(MAC_MUL, 16'h8000, 16'h8000, 1'b0, 1'b1, 1'b0);
    rd_acc();
    mac(MAC_CLR, 16'h1111, 16'h2222, 1'b0, 1'b0, 1'b0);
    rd_acc();
    for (int i = 0; i < 9; i++)
    begin
      mac(mac_op_t'(3'(1 + i % 3)), 16'($urandom()), 16'($urandom()), 1'b0, i[0], 1'b0);
      rd_acc();
    end
    mac(MAC_MUL, 16'h7abc, 16'h1357, 1'b1, 1'b0, 1'b0);
    rd(SEL_MF, mf_m[0]);
    u_iss.wr(SEL_MX1, 16'h5a5a);
    @(negedge sys_clk);
    dm_rd_sel = SEL_MX1;
    // operand file read port adds a cycle before the bus register
    repeat (2) @(negedge sys_clk);
    chk("mx1 read", 40'(data_side_bus_q), 40'(16'h5a5a));
    dm_rd_sel = SEL_NONE;
    mac(MAC_SUB, 16'h0123, 16'h5555, 1'b0, 1'b1, 1'b1);
    rd_acc();
    u_iss.wr(SEL_ACC1, 16'h8000);
    acc_m[0] = {8'hff, 16'h8000, acc_m[0][15:0]};
    rd_acc();
    u_iss.wr(SEL_ACC2, 16'h0012);
    u_iss.wr(SEL_ACC0, 16'hbeef);
    acc_m[0] = {8'h12, acc_m[0][31:16], 16'hbeef};
    rd_acc();
    @(negedge sys_clk);
    bank_sel = 1'b1;
    rd_acc();
    mac(MAC_ADD, 16'h1234, 16'h0002, 1'b0, 1'b1, 1'b0);
    rd_acc();
    @(negedge sys_clk);
    bank_sel = 1'b0;
    rd_acc();
    close_out();
  end
endmodule : alu_divide_and_mac_datapath_bench
`default_nettype wire
